// ### pkg/bclk_if.sv
`timescale 1ns/100ps
`default_nettype none
// bus clock generator to sequencer
interface bclk_if;
  logic [2:0] div_code;
  logic stretch;
  logic bclk;
  logic rise;
  modport gen (input div_code, input stretch, output bclk, output rise);
  modport user (output div_code, output stretch, input bclk, input rise);
endinterface
`default_nettype wire

// ### pkg/bus_side_pkg.sv
`default_nettype none
package bus_side_pkg;
  // slot enable decode
  localparam int SLOT_COUNT = 6;
  localparam logic [1:0] SLOT_ALIGN = 2'h0;
  localparam logic [5:0] SLOTS_ALL_OFF = 6'h3f;
  localparam logic [5:0] SLOTS_ALL_ON = 6'h00;
  // bus clock divide codes
  localparam logic [2:0] DIV_BY3 = 3'h0;
  localparam logic [2:0] DIV_BY4 = 3'h1;
  localparam logic [2:0] DIV_BY5 = 3'h2;
  localparam logic [2:0] DIV_BY6 = 3'h3;
  localparam logic [2:0] DIV_BY8 = 3'h4;
  localparam logic [3:0] CNT_RESET = 4'h0;
  // reset level of active-low strobes
  localparam logic NEG_N = 1'b1;
  localparam logic [1:0] SA_RESET = 2'h0;
  localparam logic [3:0] BE_RESET = 4'hf;
  localparam logic [2:0] BEATS_RESET = 3'h0;

  typedef enum logic [2:0] {CYC_NONE, CYC_HOST, CYC_ISA_MASTER, CYC_EISA_MASTER, CYC_DMA,
    CYC_REFRESH} cycle_e;
  typedef enum logic [1:0] {W8, W16, W32} width_e;

  function automatic logic [3:0] div_ratio(input logic [2:0] code);
    unique case (code)
      DIV_BY4: return 4'h4;
      DIV_BY5: return 4'h5;
      DIV_BY6: return 4'h6;
      DIV_BY8: return 4'h8;
      default: return 4'h3;
    endcase
  endfunction

  // bus cycles needed to move one master transfer through a narrower slave
  function automatic logic [2:0] beats(input width_e mw, input width_e sw);
    if (mw == W32 && sw == W8) return 3'h4;
    if ((mw == W32 && sw == W16) || (mw == W16 && sw == W8)) return 3'h2;
    return 3'h1;
  endfunction
endpackage
`default_nettype wire

// ### tb/eisa_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module eisa_slave_model (
  input wire logic clk, // host cpu clock
  input wire logic bclk, // bus clock
  input wire bus_side_pkg::width_e sw, // width reported
  input wire logic [1:0] waits, // bus clock waits
  input wire logic cmd_n, // command
  input wire logic start_oe, // start drive
  input wire logic start_out_n, // start level
  input wire logic exrdy_oe, // ready pulled low
  input wire logic chrdy_oe, // channel ready pulled low
  input wire logic m16_oe, // 16-bit memory pulled low
  output logic start_in_n, // start wire
  output logic exrdy_in, // ready wire
  output logic chrdy_in, // channel ready wire
  output logic ex32_n, // 32-bit slave
  output logic ex16_n, // 16-bit slave
  output logic m16_in_n, // 16-bit memory wire
  output logic nows_n // no wait states
);
  import bus_side_pkg::*;
  logic [1:0] wcnt;
  logic pb;
  logic rdy;
  // count bus clock rises in the command phase; a slow slave holds ready off
  always_ff @(posedge clk) begin
    pb <= bclk;
    if (cmd_n) begin
      wcnt <= 2'h0;
    end else if (bclk && !pb && wcnt != waits) begin
      wcnt <= wcnt + 2'h1;
    end
  end
  // released open-drain lines rise to their pull-up
  assign rdy = cmd_n || wcnt == waits;
  assign exrdy_in = rdy && !exrdy_oe;
  assign chrdy_in = rdy && !chrdy_oe;
  assign start_in_n = start_oe ? start_out_n : 1'b1;
  assign ex32_n = sw != W32;
  assign ex16_n = sw != W16;
  assign m16_in_n = !m16_oe;
  assign nows_n = 1'b1;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bus_side_pkg::*;
  cycle_e cycle;
  width_e master_width, sw;
  logic clk, sys_rst, cycle_req, host_slave_ack, tgt_isa, tgt_host, tgt_eisa_mem, is_mem;
  logic is_write, companion_burst_req, dma_burst_sel, mem_burst_ok, host_slave_burst_in_n;
  logic host_slave_ready, host_lock_in_n, host_mem16, gt1m_n, refresh_n, global_aen, wr_in;
  logic host_stretch_n, start_in_n, msburst_in_n, slburst_in_n, ex32_n, ex16_n, exrdy_in;
  logic master16_n, m16_in_n, chrdy_in, nows_n, sbhe_in_n, be_oe, mio_out, mio_oe, wr_out;
  logic wr_oe, start_out_n, start_oe, cmd_n, msburst_out_n, msburst_oe, slburst_out_n;
  logic slburst_oe, exrdy_out, exrdy_oe, lock_n, bclk, m16_out_n, m16_oe, smrdc_n, smwtc_n;
  logic mrdc_n, chrdy_out, chrdy_oe, sbhe_out_n, sa_oe, sbhe_oe, host_ready_out_n;
  logic companion_ready, master_wr, master_burst_next, slave_burst_seen, downsize_burst;
  logic isa_sbhe_n;
  logic ps = 0, pc = 1, pb = 0;
  logic [1:0] sa_in, sa_out, isa_sa, waits;
  logic [2:0] div_code;
  logic [3:0] host_be, be_in_n, be_out_n, master_be_n;
  logic [5:0] slot_address_enable;
  logic [7:0] la_addr_hi, a, cnt = 0, nb = 0;
  logic [16:0] qs[$], obs;
  logic [7:0] qb[$], qd[$];
  int n_mismatch = 0;
  int n_checks = 0;

  eisa_isa_bus_side_interface eisa_isa_bus_side_interface_i (.*);
  eisa_slave_model eisa_slave_model_i (.*);

  // levels sampled from the isa master and the decoder, one clock after their inputs
  assign obs = {slave_burst_seen, isa_sbhe_n, isa_sa, master_be_n, m16_oe, wr_out, lock_n,
    slot_address_enable};

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // take the oldest note when an answer shows; #1 lets the edge settle
  always @(posedge clk) begin
    #1;
    cnt = cnt + 8'h1;
    if (qs.size() > 0) chk(obs, qs.pop_front());
    if (pc === 1'b1 && cmd_n === 1'b0) begin
      nb = nb + 8'h1;
      chk({ps, start_oe}, 8'h2);
      chk({smwtc_n, smrdc_n, mrdc_n}, {1'b1, cycle != CYC_DMA, cycle != CYC_REFRESH});
      if (cycle == CYC_DMA) chk({sa_oe, sbhe_out_n, sa_out}, {1'b1, nb[0], nb[1:0] - 2'h1});
    end
    if (ps === 1'b0 && start_oe === 1'b1) begin
      chk(be_oe, cycle == CYC_HOST);
      if (cycle == CYC_HOST) chk({mio_oe, wr_oe, be_out_n}, {2'h3, ~host_be});
    end
    if ((host_ready_out_n === 1'b0 || companion_ready === 1'b1) && qb.size() > 0) begin
      chk({~host_ready_out_n, nb[6:0]}, qb.pop_front());
      nb = 0;
    end
    if (pb === 1'b0 && bclk === 1'b1) begin
      if (qd.size() > 0) chk(cnt, qd.pop_front());
      cnt = 0;
    end
    ps = start_oe;
    pc = cmd_n;
    pb = bclk;
  end

  // stimulus at the falling edge
  initial begin
    cycle = CYC_NONE;
    master_width = W32;
    sw = W32;
    {cycle_req, host_slave_ack, tgt_isa, tgt_host, is_mem, is_write, wr_in, sa_in} = '0;
    {companion_burst_req, dma_burst_sel, mem_burst_ok, host_mem16, div_code, waits} = '0;
    {host_slave_burst_in_n, host_lock_in_n, gt1m_n, refresh_n, global_aen} = '1;
    {host_stretch_n, msburst_in_n, slburst_in_n, master16_n, sbhe_in_n} = '1;
    {tgt_eisa_mem, sys_rst, host_slave_ready, host_be, be_in_n} = '1;
    la_addr_hi = 8'h00;
    a = 8'($urandom(76583));
    repeat (3) @(negedge clk);
    sys_rst = 0;
    // an isa master owns the bus during the decoder sweep, so its inputs get sampled
    cycle = CYC_ISA_MASTER;
    for (int i = 0; i < 100; i++) begin
      @(negedge clk);
      {global_aen, la_addr_hi, host_lock_in_n, is_write, is_mem, host_be} = $urandom;
      {gt1m_n, host_mem16, dma_burst_sel, mem_burst_ok, host_stretch_n, tgt_host} = $urandom;
      {companion_burst_req, host_slave_burst_in_n, be_in_n, wr_in, sa_in} = $urandom;
      {sbhe_in_n, master16_n, msburst_in_n, slburst_in_n} = $urandom;
      // sweep leading digits 0 to 7 both aligned and unaligned
      if (i < 32) begin
        global_aen = 0;
        la_addr_hi[7:4] = 4'(i % 8);
        la_addr_hi[1:0] = 2'(i / 16);
      end
      a = 8'h3f;
      if (!global_aen && la_addr_hi[1:0] != 2'h0) a = 8'h00;
      else if (!global_aen && la_addr_hi[7:4] inside {[1:6]}) a = a ^ (8'h1 << (la_addr_hi[7:4] - 1));
      qs.push_back({companion_burst_req && !slburst_in_n, sbhe_in_n, sa_in, be_in_n, host_mem16,
        is_write, host_lock_in_n, a[5:0]});
    end
    @(negedge clk);
    {host_stretch_n, host_lock_in_n, host_slave_ready, is_mem, gt1m_n} = '1;
    {tgt_host, is_write, be_in_n} = '0;
    cycle = CYC_NONE;
    $display("slot decode test done");
    // host cycles to 32, 16 and 8-bit slaves, then dma and refresh
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      cycle = i < 3 ? CYC_HOST : i == 3 ? CYC_DMA : CYC_REFRESH;
      sw = i == 1 ? W16 : (i == 2 || i == 3) ? W8 : W32;
      tgt_isa = i == 3;
      refresh_n = i != 4;
      waits = 2'($urandom % 3);
      qb.push_back(i < 3 ? 8'h80 | (8'h1 << i) : i == 3 ? 8'h4 : 8'h1);
      cycle_req = 1;
      for (int j = 0; j < 400 && host_ready_out_n !== 1'b0 && companion_ready !== 1'b1; j++) begin
        @(posedge clk);
        #1;
      end
      @(negedge clk);
      cycle_req = 0;
      cycle = CYC_NONE;
      refresh_n = 1;
    end
    $display("bus cycle test done");
    for (int k = 0; k < 5; k++) begin
      @(negedge clk);
      div_code = 3'(k);
      repeat (20) @(negedge clk);
      qd.push_back(k == 4 ? 8'h8 : 8'(k + 3));
      repeat (10) @(negedge clk);
    end
    $display("bus clock test done");
    chk(8'(qs.size() + qb.size() + qd.size()), 8'h0);
    final_report();
  end

  // whole run is near 400 cycles; a hang stops far past that
  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire

// ### verilog/bclk_divider.sv
`timescale 1ns/100ps
`default_nettype none
module bclk_divider (
  input wire logic clk, // host cpu clock
  input wire logic sys_rst, // synchronous reset
  bclk_if.gen bif // divided bus clock out
);
  import bus_side_pkg::*;

  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [3:0] ratio;
  logic [3:0] low_len;
  logic hold;

  // low phase first; stretch freezes the last low count so bclk stays low
  always_comb begin
    ratio = div_ratio(bif.div_code);
    low_len = ratio >> 1;
    hold = bif.stretch && (cnt == low_len - 4'h1);
    if (hold) begin
      next_cnt = cnt;
    end else if (cnt >= ratio - 4'h1) begin
      next_cnt = CNT_RESET; // also recovers when the divide code shrinks
    end else begin
      next_cnt = cnt + 4'h1;
    end
  end

  // counter and clock outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt <= CNT_RESET;
      bif.bclk <= 1'b0;
      bif.rise <= 1'b0;
    end else begin
      cnt <= next_cnt;
      bif.bclk <= (next_cnt >= low_len);
      bif.rise <= (next_cnt == low_len) && (cnt != low_len);
    end
  end

  bclk_stretch_a: assert property (@(posedge clk) disable iff (sys_rst)
    (bif.stretch && !bif.bclk && cnt == low_len - 4'h1) |=> !bif.bclk)
    else $error("bus clock rose while stretched");
endmodule
`default_nettype wire

// ### verilog/eisa_isa_bus_side_interface.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - global enable high sets all six slot enables; unaligned low addresses clear all.
// - aligned address with leading digit n selects slot n alone; zero selects none.
// - translate cycles between EISA/ISA masters and slaves of 32, 16 and 8 bits.
// - drive byte enables on unclaimed host cycles, take them as inputs otherwise.
// - drive memory/io on ISA master and host-to-slave cycles, float otherwise.
// - sample write/read from EISA masters, drive it on unclaimed host and ISA master cycles.
// - drive start for unclaimed host cycles, DMA, refresh, 8-bit ISA io, splits.
// - assert command as start negates, hold it until the cycle ends.
// - sample master burst from EISA masters, drive it for burst DMA.
// - drive slave burst for bursting host memory, sample it for companion bursts.
// - judge widths from slave size lines and split into several cycles.
// - pass EISA ready to host ready or companion ready.
// - drive EISA ready for EISA masters on host or ISA slaves and CPU-to-ISA.
// - assert bus lock whenever host lock input is asserted.
// - divide cpu clock by 3,4,5,6 or 8; low phase may stretch.
// - sample 16-bit master at both start edges to detect burst downsizing.
// - drive 16-bit memory for ISA masters on host/EISA slaves, sample otherwise.
// - standard memory strobes only for ISA memory below one megabyte.
// - drive channel ready during ISA master cycles to host or EISA slaves.
// - sample low address and high enable from ISA masters, drive them on unclaimed host, EISA-to-ISA and DMA-to-ISA-memory cycles.
// - while refresh is asserted generate memory read and command.
module eisa_isa_bus_side_interface (
  input wire logic clk, // host cpu clock
  input wire logic sys_rst, // synchronous reset
  input wire bus_side_pkg::cycle_e cycle, // owner of the current cycle
  input wire logic cycle_req, // cycle pending, level
  input wire logic host_slave_ack, // a host slave claimed the cycle
  input wire logic tgt_isa, // target is an ISA slave
  input wire logic tgt_host, // target is a host slave or companion
  input wire logic tgt_eisa_mem, // target is EISA memory
  input wire logic is_mem, // memory cycle, else io
  input wire logic is_write, // write cycle
  input wire bus_side_pkg::width_e master_width, // width of the master
  input wire logic [3:0] host_be, // host byte enables, high = lane used
  input wire logic companion_burst_req, // companion asks for bursts
  input wire logic dma_burst_sel, // burst dma selected
  input wire logic mem_burst_ok, // memory can burst
  input wire logic host_slave_burst_in_n, // host memory can burst
  input wire logic host_slave_ready, // host slave or companion ready
  input wire logic host_lock_in_n, // host lock
  input wire logic host_mem16, // host slave is 16-bit memory
  input wire logic gt1m_n, // address above one megabyte
  input wire logic refresh_n, // refresh in progress
  input wire logic global_aen, // global address enable
  input wire logic [7:0] la_addr_hi, // address bits 15..8
  input wire logic [2:0] div_code, // bus clock divide select
  input wire logic host_stretch_n, // stretch bus clock low
  input wire logic [3:0] be_in_n, // bus byte enables in
  output logic [3:0] be_out_n, // bus byte enables out
  output logic be_oe, // byte enable drive
  output logic mio_out, // memory/io out
  output logic mio_oe, // memory/io drive
  input wire logic wr_in, // write/read in
  output logic wr_out, // write/read out
  output logic wr_oe, // write/read drive
  input wire logic start_in_n, // start line level
  output logic start_out_n, // start out
  output logic start_oe, // start drive
  output logic cmd_n, // command
  input wire logic msburst_in_n, // master burst in
  output logic msburst_out_n, // master burst out, open drain
  output logic msburst_oe, // master burst drive
  input wire logic slburst_in_n, // slave burst in
  output logic slburst_out_n, // slave burst out, open drain
  output logic slburst_oe, // slave burst drive
  input wire logic ex32_n, // 32-bit slave
  input wire logic ex16_n, // 16-bit slave
  input wire logic exrdy_in, // EISA ready in
  output logic exrdy_out, // EISA ready out, open drain
  output logic exrdy_oe, // EISA ready drive
  output logic lock_n, // bus lock
  output logic bclk, // bus clock
  input wire logic master16_n, // 16-bit master
  input wire logic m16_in_n, // 16-bit memory in
  output logic m16_out_n, // 16-bit memory out, open drain
  output logic m16_oe, // 16-bit memory drive
  output logic smrdc_n, // standard memory read
  output logic smwtc_n, // standard memory write
  output logic mrdc_n, // memory read
  input wire logic chrdy_in, // channel ready in
  output logic chrdy_out, // channel ready out, open drain
  output logic chrdy_oe, // channel ready drive
  input wire logic nows_n, // no wait states
  input wire logic [1:0] sa_in, // low address in
  output logic [1:0] sa_out, // low address out
  output logic sa_oe, // low address drive
  input wire logic sbhe_in_n, // high byte enable in
  output logic sbhe_out_n, // high byte enable out
  output logic sbhe_oe, // high byte enable drive
  output logic [bus_side_pkg::SLOT_COUNT-1:0] slot_address_enable, // per-slot enables
  output logic host_ready_out_n, // host ready pulse
  output logic companion_ready, // companion ready pulse
  output logic master_wr, // sampled master write
  output logic [3:0] master_be_n, // sampled master byte enables
  output logic master_burst_next, // master will burst next
  output logic slave_burst_seen, // slave accepts bursts
  output logic downsize_burst, // 32-bit master downsized to burst
  output logic [1:0] isa_sa, // sampled ISA master address
  output logic isa_sbhe_n // sampled ISA master high enable
);
  import bus_side_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_EXT, ST_CMD} seq_e;

  seq_e state;
  seq_e next_state;
  logic [2:0] beats_left;
  logic [2:0] next_beats;
  logic [1:0] beat_idx;
  width_e slave_w;
  width_e slave_w_q;
  width_e master_eff;
  logic need_start;
  logic done;
  logic host_fwd;
  logic isa_mst;
  logic eisa_mst;
  logic start_q_n;
  logic m16_first_n;
  logic [3:0] be_src;
  logic [3:0] lane_mask;
  logic drive_sa;
  logic drive_ex;
  logic isa_mem_cmd;

  bclk_if bif ();

  slot_enable_decoder #(.SLOTS(SLOT_COUNT)) u_slots (
    .clk(clk),
    .sys_rst(sys_rst),
    .global_aen(global_aen),
    .addr_hi(la_addr_hi),
    .slot_address_enable(slot_address_enable)
  );

  bclk_divider u_bclk (
    .clk(clk),
    .sys_rst(sys_rst),
    .bif(bif.gen)
  );

  assign bif.div_code = div_code;
  assign bif.stretch = !host_stretch_n;
  assign bclk = bif.bclk;

  // cycle owner decode and slave width from the size lines
  always_comb begin
    host_fwd = (cycle == CYC_HOST) && !host_slave_ack;
    isa_mst = (cycle == CYC_ISA_MASTER);
    eisa_mst = (cycle == CYC_EISA_MASTER);
    master_eff = (cycle == CYC_HOST) ? W32 : master_width;
    if (!ex32_n) begin
      slave_w = W32;
    end else if (!ex16_n || !m16_in_n) begin
      slave_w = W16;
    end else begin
      slave_w = W8;
    end
  end

  // which cycles this end must start on the bus itself
  always_comb begin
    unique case (cycle)
      CYC_HOST: need_start = !host_slave_ack;
      CYC_DMA, CYC_REFRESH: need_start = 1'b1;
      CYC_ISA_MASTER: need_start = !is_mem && (slave_w == W8);
      CYC_EISA_MASTER: need_start = beats(master_eff, slave_w) > 3'h1;
      default: need_start = 1'b0;
    endcase
    if (!refresh_n) begin
      need_start = 1'b1;
    end
  end

  // end of the last beat; slaves may cut the wait with no-wait-states
  assign done = (state == ST_CMD) && bif.rise && (exrdy_in || !nows_n)
    && (beats_left <= 3'h1);

  // start/command sequencer, one bus cycle per beat
  always_comb begin
    next_state = state;
    next_beats = beats_left;
    unique case (state)
      ST_IDLE: begin
        if (cycle_req && need_start) begin
          next_state = ST_START;
          next_beats = beats(master_eff, slave_w);
        end else if (!start_in_n) begin
          next_state = ST_EXT; // a master started its own cycle
          next_beats = 3'h1;
        end
      end
      ST_START: begin
        if (bif.rise) begin
          next_state = ST_CMD;
        end
      end
      ST_EXT: begin
        if (start_in_n) begin
          next_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (done) begin
          next_state = ST_IDLE;
        end else if (bif.rise && (exrdy_in || !nows_n)) begin
          next_state = ST_START;
          next_beats = beats_left - 3'h1;
        end
      end
    endcase
  end

  // start and command leave the same edge, so command meets start's negation
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      beats_left <= BEATS_RESET;
      start_out_n <= NEG_N;
      start_oe <= 1'b0;
      cmd_n <= NEG_N;
    end else begin
      state <= next_state;
      beats_left <= next_beats;
      start_out_n <= (next_state != ST_START);
      start_oe <= (next_state == ST_START);
      cmd_n <= (next_state != ST_CMD);
    end
  end

  // beat position and the slave width latched while the sequencer is idle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      beat_idx <= 2'h0;
      slave_w_q <= W32;
    end else if (state == ST_IDLE) begin
      beat_idx <= 2'h0;
      slave_w_q <= slave_w;
    end else if (state == ST_CMD && next_state == ST_START) begin
      beat_idx <= beat_idx + 2'h1;
    end
  end

  // lanes of the current beat; narrow slaves take the lanes in ascending order
  always_comb begin
    be_src = (cycle == CYC_HOST) ? host_be : ~be_in_n;
    unique case (slave_w_q)
      W8: lane_mask = 4'h1 << beat_idx;
      W16: lane_mask = beat_idx[0] ? 4'hc : 4'h3;
      default: lane_mask = 4'hf;
    endcase
    drive_sa = host_fwd || (eisa_mst && tgt_isa) || ((cycle == CYC_DMA) && tgt_isa && is_mem);
    drive_ex = (eisa_mst && (tgt_host || tgt_isa)) || (host_fwd && tgt_isa && state != ST_IDLE);
    isa_mem_cmd = is_mem && tgt_isa && (slave_w_q != W32) && gt1m_n && (next_state == ST_CMD)
      && (cycle inside {CYC_HOST, CYC_DMA, CYC_EISA_MASTER, CYC_ISA_MASTER});
  end

  // lowest enabled byte gives the low address bits
  function automatic logic [1:0] low_lane(input logic [3:0] lanes);
    if (lanes[0]) return 2'h0;
    if (lanes[1]) return 2'h1;
    if (lanes[2]) return 2'h2;
    if (lanes[3]) return 2'h3;
    return 2'h0;
  endfunction

  // direction of each shared line by cycle owner
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      be_oe <= 1'b0;
      be_out_n <= BE_RESET;
      mio_oe <= 1'b0;
      mio_out <= 1'b0;
      wr_oe <= 1'b0;
      wr_out <= 1'b0;
      sa_oe <= 1'b0;
      sa_out <= SA_RESET;
      sbhe_oe <= 1'b0;
      sbhe_out_n <= NEG_N;
    end else begin
      be_oe <= host_fwd;
      be_out_n <= ~host_be;
      mio_oe <= isa_mst || host_fwd;
      mio_out <= is_mem;
      wr_oe <= isa_mst || host_fwd;
      wr_out <= is_write;
      sa_oe <= drive_sa;
      sa_out <= low_lane(be_src & lane_mask);
      sbhe_oe <= drive_sa;
      sbhe_out_n <= !(|(be_src & lane_mask & 4'ha));
    end
  end

  // values sampled from masters and slaves
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      master_wr <= 1'b0;
      master_be_n <= BE_RESET;
      master_burst_next <= 1'b0;
      slave_burst_seen <= 1'b0;
      isa_sa <= SA_RESET;
      isa_sbhe_n <= NEG_N;
    end else begin
      if (eisa_mst) begin
        master_wr <= wr_in;
        master_burst_next <= !msburst_in_n;
      end
      if (isa_mst || eisa_mst || cycle == CYC_DMA || cycle == CYC_REFRESH) begin
        master_be_n <= be_in_n;
      end
      if (isa_mst) begin
        isa_sa <= sa_in;
        isa_sbhe_n <= sbhe_in_n;
      end
      slave_burst_seen <= companion_burst_req && !slburst_in_n;
    end
  end

  // 16-bit master checked at both start edges; held until the next start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_q_n <= NEG_N;
      m16_first_n <= NEG_N;
      downsize_burst <= 1'b0;
    end else begin
      start_q_n <= start_in_n;
      if (start_q_n && !start_in_n) begin
        m16_first_n <= master16_n;
      end
      if (!start_q_n && start_in_n) begin
        downsize_burst <= m16_first_n && !master16_n;
      end
    end
  end

  // open-drain drives; the two ready lines pull low only while not ready, the others while their condition holds
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msburst_oe <= 1'b0;
      slburst_oe <= 1'b0;
      exrdy_oe <= 1'b0;
      m16_oe <= 1'b0;
      chrdy_oe <= 1'b0;
    end else begin
      msburst_oe <= (cycle == CYC_DMA) && dma_burst_sel && mem_burst_ok;
      slburst_oe <= eisa_mst && tgt_host && !host_slave_burst_in_n;
      exrdy_oe <= drive_ex && !(tgt_isa ? chrdy_in : host_slave_ready);
      m16_oe <= isa_mst && (tgt_host || tgt_eisa_mem) && host_mem16;
      chrdy_oe <= isa_mst && (tgt_host || !tgt_isa) && !host_slave_ready;
    end
  end

  assign msburst_out_n = 1'b0;
  assign slburst_out_n = 1'b0;
  assign exrdy_out = 1'b0;
  assign m16_out_n = 1'b0;
  assign chrdy_out = 1'b0;

  // ready relay, lock and memory strobes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_ready_out_n <= NEG_N;
      companion_ready <= 1'b0;
      lock_n <= NEG_N;
      smrdc_n <= NEG_N;
      smwtc_n <= NEG_N;
      mrdc_n <= NEG_N;
    end else begin
      host_ready_out_n <= !(done && cycle == CYC_HOST);
      companion_ready <= done && (cycle == CYC_DMA || cycle == CYC_REFRESH);
      lock_n <= host_lock_in_n;
      smrdc_n <= !(isa_mem_cmd && !is_write);
      smwtc_n <= !(isa_mem_cmd && is_write);
      mrdc_n <= !(!refresh_n && next_state == ST_CMD);
    end
  end

  cmd_on_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_START ##1 state == ST_CMD) |-> !cmd_n && start_out_n && !start_oe)
    else $error("command not asserted as start negated");
  cmd_held_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == ST_CMD && !(bif.rise && (exrdy_in || !nows_n))) |=> !cmd_n)
    else $error("command dropped before cycle end");
  lock_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    !host_lock_in_n |=> !lock_n)
    else $error("bus lock not following host lock");
  be_input_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cycle inside {CYC_EISA_MASTER, CYC_ISA_MASTER, CYC_DMA}) |=> !be_oe)
    else $error("byte enables driven during a master cycle");
  mio_float_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cycle inside {CYC_DMA, CYC_EISA_MASTER}) |=> !mio_oe)
    else $error("memory/io driven when it must float");
  wr_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cycle == CYC_ISA_MASTER) |=> wr_oe && wr_out == $past(is_write))
    else $error("write/read not driven for isa master");
  host_ready_a: assert property (@(posedge clk) disable iff (sys_rst)
    (done && cycle == CYC_HOST) |=> !host_ready_out_n ##1 host_ready_out_n)
    else $error("host ready not a one-cycle pulse at cycle end");
  smem_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!smrdc_n || !smwtc_n) |-> $past(gt1m_n) && $past(tgt_isa))
    else $error("standard strobe above one megabyte");
  refresh_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!refresh_n && state == ST_START ##1 state == ST_CMD && !refresh_n) |-> !mrdc_n && !cmd_n)
    else $error("refresh without memory read");
endmodule
`default_nettype wire

// ### verilog/slot_enable_decoder.sv
`timescale 1ns/100ps
`default_nettype none
module slot_enable_decoder #(
  parameter int SLOTS = bus_side_pkg::SLOT_COUNT
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic global_aen, // global address enable
  input wire logic [7:0] addr_hi, // address bits 15..8
  output logic [SLOTS-1:0] slot_address_enable // per-slot enables
);
  import bus_side_pkg::*;

  // per-slot decode, registered so slots see a clean level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slot_address_enable <= '1;
    end else if (global_aen) begin
      slot_address_enable <= '1;
    end else if (addr_hi[1:0] != SLOT_ALIGN) begin
      slot_address_enable <= '0;
    end else begin
      for (int i = 0; i < SLOTS; i++) begin
        slot_address_enable[i] <= (addr_hi[7:4] != 4'(i + 1));
      end
    end
  end

  slot_all_high_a: assert property (@(posedge clk) disable iff (sys_rst)
    global_aen |=> &slot_address_enable)
    else $error("slot enables not all high with global enable high");
  slot_one_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!global_aen && addr_hi == 8'h14) |=> slot_address_enable[0] == 1'b0
      && &slot_address_enable[SLOTS-1:1])
    else $error("slot one not selected alone");
endmodule
`default_nettype wire
